// ---- logic/lpo_pkg.sv ----
/*
 * Shared constants, types and helper functions of the LVDS pixel output
 * formatter with its strap and repeater configuration.
 * Assumes one 50 MHz system clock and pins that are synchronised inside lpo_top.
 */
package lpo_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ           = 50;
	localparam int PCLK_NORM_MIN_MHZ = 15;
	localparam int PCLK_NORM_MAX_MHZ = 85;
	localparam int PCLK_LF_MIN_MHZ   = 5;
	localparam logic [7:0] NORM_MAX_PER_CYC =
		8'((CLK_MHZ + PCLK_NORM_MIN_MHZ - 1) / PCLK_NORM_MIN_MHZ);
	localparam logic [7:0] LF_MAX_PER_CYC =
		8'((CLK_MHZ + PCLK_LF_MIN_MHZ - 1) / PCLK_LF_MIN_MHZ);
	localparam logic [7:0] LF_MIN_PER_CYC = 8'(CLK_MHZ / PCLK_NORM_MIN_MHZ);
	localparam logic [2:0] STRAP_SETTLE_CYC = 3'h4;

	// ----------------------------------------------------------------
	// Frame layout
	// ----------------------------------------------------------------
	localparam int BITS_PER_LANE = 7;
	localparam int DATA_LANES    = 4;
	localparam int FRAME_BITS    = 28;
	localparam int PIXEL_W       = 27;
	localparam logic [6:0] CLK_LANE_PATTERN = 7'h63;
	localparam logic [2:0] LINE_MULT_NORMAL = 3'h1;
	localparam logic [2:0] LINE_MULT_LF     = 3'h4;
	localparam logic [3:0] MODE_BACKWARD_COMPAT_CODE   = 4'h8;

	// ----------------------------------------------------------------
	// Synchronised pin vector positions and reset values
	// ----------------------------------------------------------------
	localparam int SYNC_W   = 12;
	localparam int PIN_PCLK = 0;
	localparam int PIN_MAP  = 1;
	localparam int PIN_LF   = 2;
	localparam int PIN_MODE = 3;
	localparam int PIN_USCL = 7;
	localparam int PIN_USDA = 8;
	localparam int PIN_DSCL = 9;
	localparam int PIN_DSDA = 10;
	localparam int PIN_INT  = 11;
	localparam logic [11:0] SYNC_RST = 12'hf80;

	typedef enum logic {SER_IDLE, SER_SHIFT} lpo_ser_t;
	typedef enum logic [1:0] {I2C_IDLE, I2C_START, I2C_ADDR, I2C_DATA} lpo_i2c_t;

	// Returns {repeater, backward_compat, audio_port_b, long_cable}.
	function automatic logic [3:0] lpo_decode_mode(input logic [3:0] code);
		logic [3:0] f;
		f = 4'h0;
		if (code == MODE_BACKWARD_COMPAT_CODE) begin
			f = 4'h4;
		end else if (code < MODE_BACKWARD_COMPAT_CODE) begin
			f = {code[1], 1'b0, code[0], code[2]};
		end
		return f;
	endfunction : lpo_decode_mode

	// Pixel is {red[7:0], green[7:0], blue[7:0], hsync, vsync, de}.
	function automatic logic [27:0] lpo_build_frame(input logic [26:0] pix,
		input logic map_msb, input logic d18);
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [5:0] r6;
		logic [5:0] g6;
		logic [5:0] b6;
		logic [5:0] lo3;
		logic [6:0] lane3;
		r     = pix[26:19];
		g     = pix[18:11];
		b     = pix[10:3];
		r6    = (map_msb && !d18) ? r[5:0] : r[7:2];
		g6    = (map_msb && !d18) ? g[5:0] : g[7:2];
		b6    = (map_msb && !d18) ? b[5:0] : b[7:2];
		lo3   = map_msb ? {r[7:6], g[7:6], b[7:6]} : {r[1:0], g[1:0], b[1:0]};
		lane3 = d18 ? 7'h00 : {lo3, 1'b0};
		return {lane3, pix[0], pix[1], pix[2], b6[5:2], b6[1:0], g6[5:1], g6[0], r6};
	endfunction : lpo_build_frame

endpackage : lpo_pkg

// ---- logic/lpo_fifo.sv ----
/*
 * Small shift-register FIFO with valid and ready on both sides.
 * Assumes one clock; the head word and both flags come from registers.
 */
`timescale 1ns/100ps
module lpo_fifo #(
	parameter int WIDTH = 27,
	parameter int DEPTH = 8
) (
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	output logic [WIDTH-1:0]      out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [CW-1:0]    count;
	logic [CW-1:0]    next_count;
	logic             push;
	logic             pop;

	assign push       = in_valid_i && in_ready_o;
	assign pop        = out_ready_i && out_valid_o;
	assign out_data_o = mem[0];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + CW'(1);
		end else if (pop && !push) begin
			next_count = count - CW'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			count       <= '0;
			in_ready_o  <= 1'b1;
			out_valid_o <= 1'b0;
		end else begin
			count       <= next_count;
			in_ready_o  <= next_count < CW'(DEPTH);
			out_valid_o <= next_count != '0;
		end
	end

	// Entries move towards the head on a pop; a push lands behind the last.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem[i] <= '0;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				if (push && (CW'(i) == (pop ? count - CW'(1) : count))) begin
					mem[i] <= in_data_i;
				end else if (pop) begin
					mem[i] <= (i == DEPTH - 1) ? '0 : mem[i + 1];
				end
			end
		end
	end

endmodule : lpo_fifo

// ---- logic/lpo_top.sv ----
/*
 * LVDS pixel output formatter: buffers pixels, serialises one frame per
 * pixel clock on four data lanes and a clock lane, decodes straps and
 * forwards control bus and interrupt in repeater operation.
 * Assumes pixels arrive on clk_i; straps, pixel clock and bus pins are
 * asynchronous; rst_n_i is the active-low power-down input.
 */
`timescale 1ns/100ps
module lpo_top
	import lpo_pkg::*;
#(
	parameter int BIT_DIV    = 1,
	parameter int FIFO_DEPTH = 8
) (
	input  wire logic               clk_i,
	input  wire logic               rst_n_i,
	input  wire logic [PIXEL_W-1:0] pix_data_i,
	input  wire logic               pix_valid_i,
	output logic                    pix_ready_o,
	input  wire logic               pixel_clk_i,
	input  wire logic               color_map_strap_i,
	input  wire logic               color_map_reg_i,
	input  wire logic               color_map_reg_en_i,
	input  wire logic               color_depth_18_i,
	input  wire logic               low_freq_strap_i,
	input  wire logic               low_freq_reg_i,
	input  wire logic               low_freq_reg_en_i,
	input  wire logic [3:0]         mode_sel_code_i,
	input  wire logic               cfg_reg_en_i,
	input  wire logic               repeat_reg_i,
	input  wire logic               backward_compat_reg_i,
	input  wire logic               audio_port_b_reg_i,
	input  wire logic               long_cable_reg_i,
	input  wire logic               alias_enable_i,
	input  wire logic [6:0]         alias_xor_i,
	input  wire logic               up_scl_i,
	output logic                    up_scl_o,
	output logic                    up_scl_oe_n_o,
	input  wire logic               up_sda_i,
	output logic                    up_sda_o,
	output logic                    up_sda_oe_n_o,
	input  wire logic               dn_scl_i,
	output logic                    dn_scl_o,
	output logic                    dn_scl_oe_n_o,
	input  wire logic               dn_sda_i,
	output logic                    dn_sda_o,
	output logic                    dn_sda_oe_n_o,
	input  wire logic               interrupt_in_n_i,
	output logic                    interrupt_out_n_o,
	output logic                    interrupt_out_oe_n_o,
	output logic [DATA_LANES-1:0]   lvds_data_lanes_o,
	output logic                    lvds_clock_out_o,
	output logic                    color_map_select_o,
	output logic                    low_freq_mode_o,
	output logic                    repeater_mode_o,
	output logic                    backward_compat_o,
	output logic                    audio_port_b_select_o,
	output logic                    long_cable_mode_o,
	output logic [2:0]              line_rate_mult_o,
	output logic                    pclk_out_of_range_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [SYNC_W-1:0] pin_raw;
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [SYNC_W-1:0] sync_c;
	logic [SYNC_W-1:0] pins_s;
	logic [SYNC_W-1:0] agree;

	assign pin_raw = {interrupt_in_n_i, dn_sda_i, dn_scl_i, up_sda_i, up_scl_i,
		mode_sel_code_i, low_freq_strap_i, color_map_strap_i, pixel_clk_i};
	assign agree   = ~(sync_b ^ sync_c);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync_a <= SYNC_RST;
			sync_b <= SYNC_RST;
			sync_c <= SYNC_RST;
			pins_s <= SYNC_RST;
		end else begin
			sync_a <= pin_raw;
			sync_b <= sync_a;
			sync_c <= sync_b;
			pins_s <= (agree & sync_c) | (~agree & pins_s);
		end
	end

	// ----------------------------------------------------------------
	// Strap capture and configuration
	// ----------------------------------------------------------------
	logic [2:0] cap_cnt;
	logic       cfg_taken;
	logic [3:0] strap_mode;
	logic       strap_map;
	logic       lf_mode;
	logic [3:0] cfg_flags;

	assign cfg_flags = cfg_reg_en_i ?
		{repeat_reg_i, backward_compat_reg_i, audio_port_b_reg_i, long_cable_reg_i} :
		strap_mode;

	// Straps are caught once the synchroniser has settled after power-down.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cap_cnt    <= 3'h0;
			cfg_taken  <= 1'b0;
			strap_mode <= 4'h0;
			strap_map  <= 1'b0;
			lf_mode    <= 1'b0;
		end else if (!cfg_taken) begin
			cap_cnt <= cap_cnt + 3'h1;
			if (cap_cnt == STRAP_SETTLE_CYC) begin
				cfg_taken  <= 1'b1;
				strap_mode <= lpo_decode_mode(pins_s[PIN_MODE +: 4]);
				strap_map  <= pins_s[PIN_MAP];
				lf_mode    <= low_freq_reg_en_i ? low_freq_reg_i : pins_s[PIN_LF];
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			color_map_select_o    <= 1'b0;
			low_freq_mode_o       <= 1'b0;
			repeater_mode_o       <= 1'b0;
			backward_compat_o     <= 1'b0;
			audio_port_b_select_o <= 1'b0;
			long_cable_mode_o     <= 1'b0;
			line_rate_mult_o      <= LINE_MULT_NORMAL;
		end else if (cfg_taken) begin
			color_map_select_o    <= color_map_reg_en_i ? color_map_reg_i : strap_map;
			low_freq_mode_o       <= lf_mode;
			repeater_mode_o       <= cfg_flags[3];
			backward_compat_o     <= cfg_flags[2];
			audio_port_b_select_o <= cfg_flags[1];
			long_cable_mode_o     <= cfg_flags[0];
			line_rate_mult_o      <= (lf_mode && !cfg_flags[2]) ? LINE_MULT_LF :
				LINE_MULT_NORMAL;
		end
	end

	// ----------------------------------------------------------------
	// Pixel buffer
	// ----------------------------------------------------------------
	logic [PIXEL_W-1:0] fifo_data;
	logic               fifo_valid;
	logic               pclk_prev;
	logic               pclk_rise;

	assign pclk_rise = pins_s[PIN_PCLK] && !pclk_prev;

	lpo_fifo #(
		.WIDTH (PIXEL_W),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.in_data_i   (pix_data_i),
		.in_valid_i  (pix_valid_i),
		.in_ready_o  (pix_ready_o),
		.out_data_o  (fifo_data),
		.out_valid_o (fifo_valid),
		.out_ready_i (pclk_rise)
	);

	// ----------------------------------------------------------------
	// Frame serialiser
	// ----------------------------------------------------------------
	logic [7:0]            div_cnt;
	logic                  bit_en;
	lpo_ser_t              ser_state;
	logic [2:0]            bit_idx;
	logic [FRAME_BITS-1:0] frame;
	logic [FRAME_BITS-1:0] next_frame;

	assign bit_en     = div_cnt == 8'(BIT_DIV - 1);
	assign next_frame = lpo_build_frame(fifo_valid ? fifo_data : '0,
		color_map_select_o, color_depth_18_i);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_cnt <= 8'h00;
		end else if (pclk_rise || bit_en) begin
			div_cnt <= 8'h00;
		end else begin
			div_cnt <= div_cnt + 8'h01;
		end
	end

	// An empty buffer still yields a frame, sent blank with data enable low.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pclk_prev         <= 1'b0;
			ser_state         <= SER_IDLE;
			bit_idx           <= 3'h0;
			frame             <= '0;
			lvds_data_lanes_o <= '0;
			lvds_clock_out_o  <= 1'b0;
		end else begin
			pclk_prev <= pins_s[PIN_PCLK];
			case (ser_state)
				SER_IDLE: begin
					if (pclk_rise) begin
						frame     <= next_frame;
						ser_state <= SER_SHIFT;
						bit_idx   <= 3'h5;
						for (int l = 0; l < DATA_LANES; l++) begin
							lvds_data_lanes_o[l] <= next_frame[l * BITS_PER_LANE + 6];
						end
						lvds_clock_out_o <= CLK_LANE_PATTERN[6];
					end
				end
				SER_SHIFT: begin
					if (pclk_rise) begin
						frame   <= next_frame;
						bit_idx <= 3'h5;
						for (int l = 0; l < DATA_LANES; l++) begin
							lvds_data_lanes_o[l] <= next_frame[l * BITS_PER_LANE + 6];
						end
						lvds_clock_out_o <= CLK_LANE_PATTERN[6];
					end else if (bit_en) begin
						for (int l = 0; l < DATA_LANES; l++) begin
							lvds_data_lanes_o[l] <= frame[l * BITS_PER_LANE + int'(bit_idx)];
						end
						lvds_clock_out_o <= CLK_LANE_PATTERN[bit_idx];
						if (bit_idx == 3'h0) begin
							ser_state <= SER_IDLE;
						end else begin
							bit_idx <= bit_idx - 3'h1;
						end
					end
				end
				default: begin
					ser_state <= SER_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Pixel clock range monitor
	// ----------------------------------------------------------------
	logic [7:0] per_cnt;
	logic [7:0] per_meas;
	logic       rise_seen;

	assign per_meas = per_cnt + 8'h01;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			per_cnt             <= 8'h00;
			rise_seen           <= 1'b0;
			pclk_out_of_range_o <= 1'b0;
		end else if (pclk_rise) begin
			per_cnt   <= 8'h00;
			rise_seen <= 1'b1;
			if (rise_seen) begin
				if (low_freq_mode_o) begin
					pclk_out_of_range_o <= (per_meas > LF_MAX_PER_CYC) ||
						(per_meas < LF_MIN_PER_CYC);
				end else begin
					pclk_out_of_range_o <= per_meas > NORM_MAX_PER_CYC;
				end
			end
		end else if (per_cnt != 8'hff) begin
			per_cnt <= per_cnt + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// Control bus forwarding
	// ----------------------------------------------------------------
	lpo_i2c_t   i2c_state;
	logic [2:0] addr_bit;
	logic       u_scl_prev;
	logic       u_sda_prev;
	logic       u_scl;
	logic       u_sda;
	logic       d_scl;
	logic       d_sda;
	logic       alias_bit;
	logic       fwd;
	logic [3:0] line_lvl;
	logic [3:0] line_oe_n;
	logic [3:0] line_free;
	logic [3:0] echo_wait;

	assign u_scl     = pins_s[PIN_USCL];
	assign u_sda     = pins_s[PIN_USDA];
	assign d_scl     = pins_s[PIN_DSCL];
	assign d_sda     = pins_s[PIN_DSDA];
	assign fwd       = repeater_mode_o;
	assign alias_bit = alias_enable_i && (i2c_state == I2C_ADDR) &&
		alias_xor_i[3'h6 - addr_bit];
	assign up_scl_o  = 1'b0;
	assign up_sda_o  = 1'b0;
	assign dn_scl_o  = 1'b0;
	assign dn_sda_o  = 1'b0;
	assign interrupt_out_n_o = 1'b0;
	assign line_lvl  = {d_sda, d_scl, u_sda, u_scl};
	assign line_oe_n = {dn_sda_oe_n_o, dn_scl_oe_n_o, up_sda_oe_n_o, up_scl_oe_n_o};
	assign line_free = line_oe_n & ~echo_wait;

	// A released line is ignored until its synchronised level reads high again,
	// so the delayed view of our own low is never passed back across.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			echo_wait <= 4'h0;
		end else begin
			echo_wait <= ~line_oe_n | (echo_wait & ~line_lvl);
		end
	end

	// The address phase is tracked so that its bits can be remapped.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			i2c_state  <= I2C_IDLE;
			addr_bit   <= 3'h0;
			u_scl_prev <= 1'b1;
			u_sda_prev <= 1'b1;
		end else begin
			u_scl_prev <= u_scl;
			u_sda_prev <= u_sda;
			if (u_scl && u_sda_prev && !u_sda) begin
				i2c_state <= I2C_START;
				addr_bit  <= 3'h0;
			end else if (u_scl && !u_sda_prev && u_sda) begin
				i2c_state <= I2C_IDLE;
			end else if (u_scl_prev && !u_scl) begin
				case (i2c_state)
					I2C_START: i2c_state <= I2C_ADDR;
					I2C_ADDR: begin
						if (addr_bit == 3'h6) begin
							i2c_state <= I2C_DATA;
						end else begin
							addr_bit <= addr_bit + 3'h1;
						end
					end
					I2C_DATA: i2c_state <= I2C_DATA;
					I2C_IDLE: i2c_state <= I2C_IDLE;
					default:  i2c_state <= I2C_IDLE;
				endcase
			end
		end
	end

	// A side is pulled low only when the low level is not our own echo, or when an aliased address bit inverts the down data line.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			up_scl_oe_n_o        <= 1'b1;
			up_sda_oe_n_o        <= 1'b1;
			dn_scl_oe_n_o        <= 1'b1;
			dn_sda_oe_n_o        <= 1'b1;
			interrupt_out_oe_n_o <= 1'b1;
		end else begin
			dn_scl_oe_n_o <= !(fwd && !u_scl && line_free[0]);
			up_scl_oe_n_o <= !(fwd && !d_scl && line_free[2]);
			dn_sda_oe_n_o <= !(fwd && ((!u_sda && line_free[1]) ^ alias_bit));
			up_sda_oe_n_o <= !(fwd && !d_sda && line_free[3] && i2c_state != I2C_ADDR);
			interrupt_out_oe_n_o <= !(fwd && !pins_s[PIN_INT]);
		end
	end

endmodule : lpo_top

// ---- verification/lpo_top_sva.sv ----
/*
 * Port-level checks of the pixel output formatter.
 * Assumes it is bound into lpo_top, with one clock and an active-low reset.
 */
`timescale 1ns/100ps
module lpo_top_sva (
	input wire logic       clk_i,
	input wire logic       rst_n_i,
	input wire logic       cfg_reg_en_i,
	input wire logic       up_scl_i,
	input wire logic       interrupt_in_n_i,
	input wire logic       up_scl_oe_n_o,
	input wire logic       up_sda_oe_n_o,
	input wire logic       dn_scl_oe_n_o,
	input wire logic       dn_sda_oe_n_o,
	input wire logic       interrupt_out_oe_n_o,
	input wire logic       lvds_clock_out_o,
	input wire logic       low_freq_mode_o,
	input wire logic       repeater_mode_o,
	input wire logic       backward_compat_o,
	input wire logic       audio_port_b_select_o,
	input wire logic       long_cable_mode_o,
	input wire logic [2:0] line_rate_mult_o
);
	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	sequence clk_low_s;
		!lvds_clock_out_o [*3];
	endsequence
	sequence clk_high_s;
		lvds_clock_out_o [*2];
	endsequence

	clk_pattern_a : assert property (
		$fell(lvds_clock_out_o) |-> $past(lvds_clock_out_o, 2) ##0 clk_low_s ##1 clk_high_s)
		else $error("clock lane pattern broken");
	lf_mult_a : assert property (
		(low_freq_mode_o && !backward_compat_o) [*3] |-> line_rate_mult_o == 3'h4)
		else $error("low frequency line rate not four");
	backward_compat_mult_a : assert property (
		backward_compat_o [*3] |-> line_rate_mult_o == 3'h1)
		else $error("compat line rate not one");
	norm_mult_a : assert property (
		!low_freq_mode_o [*3] |-> line_rate_mult_o == 3'h1)
		else $error("normal line rate not one");
	mode_excl_a : assert property (
		(!cfg_reg_en_i && backward_compat_o) [*3]
		|-> !(repeater_mode_o || audio_port_b_select_o || long_cable_mode_o))
		else $error("compat mode with other flags");
	int_fwd_a : assert property (
		(repeater_mode_o && !interrupt_in_n_i) [*8] |-> !interrupt_out_oe_n_o)
		else $error("interrupt not forwarded");
	scl_fwd_a : assert property (
		(repeater_mode_o && !up_scl_i && up_scl_oe_n_o) [*8] |-> !dn_scl_oe_n_o)
		else $error("clock line not forwarded");
	bus_quiet_a : assert property (
		!repeater_mode_o [*2] |-> dn_scl_oe_n_o && dn_sda_oe_n_o && up_sda_oe_n_o
		&& up_scl_oe_n_o && interrupt_out_oe_n_o)
		else $error("line pulled outside repeater mode");
endmodule : lpo_top_sva

// ---- verification/lpo_panel_model.sv ----
/*
 * Receiving panel: gathers seven bits a lane, flags each whole frame.
 * Assumes lane bits step once a system clock.
 */
`timescale 1ns/100ps
module lpo_panel_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [3:0] lanes_i,
	input  wire logic       clock_i,
	output logic [27:0]     frame_o,
	output logic            frame_stb_o
);
	// ----------------------------------------------------------------
	// Deserialiser
	// ----------------------------------------------------------------
	logic [6:0] hist_c;
	logic [6:0] hist_l [4];
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			hist_c <= 7'h00;
			for (int l = 0; l < 4; l++) hist_l[l] <= 7'h00;
		end else begin
			hist_c <= {hist_c[5:0], clock_i};
			for (int l = 0; l < 4; l++) hist_l[l] <= {hist_l[l][5:0], lanes_i[l]};
		end
	end
	assign frame_stb_o = (hist_c == 7'h63);
	assign frame_o = {hist_l[3], hist_l[2], hist_l[1], hist_l[0]};
endmodule : lpo_panel_model

// ---- verification/lpo_top_test.sv ----
/*
 * Bench of the pixel output formatter: straps, overrides, framing, buffer.
 * Assumes the design, the panel model and the checker are compiled first.
 */
`timescale 1ns/100ps
module lpo_top_test
	import lpo_pkg::*;
;
	// ----------------------------------------------------------------
	// Stimulus and checks
	// ----------------------------------------------------------------
	logic        clk_i = 1'b0, rst_n_i = 1'b0, pix_valid_i = 1'b0, pixel_clk_i = 1'b0;
	logic [26:0] pix_data_i = 27'h0;
	logic        color_map_strap_i = 1'b0, color_map_reg_i = 1'b0, color_map_reg_en_i = 1'b0;
	logic        color_depth_18_i = 1'b0, low_freq_strap_i = 1'b0, low_freq_reg_i = 1'b0;
	logic        low_freq_reg_en_i = 1'b0, cfg_reg_en_i = 1'b0, repeat_reg_i = 1'b0;
	logic        backward_compat_reg_i = 1'b0, audio_port_b_reg_i = 1'b0;
	logic        long_cable_reg_i = 1'b0, alias_enable_i = 1'b0;
	logic [6:0]  alias_xor_i = 7'h00;
	logic [3:0]  mode_sel_code_i = 4'h0;
	logic        up_m_scl = 1'b1, up_m_sda = 1'b1, dn_s_sda = 1'b1, int_drv = 1'b1;
	logic        pclk_run = 1'b0, panel_stb, pix_ready_o, up_scl_o, up_scl_oe_n_o, up_sda_o;
	logic        up_sda_oe_n_o, dn_scl_o, dn_scl_oe_n_o, dn_sda_o, dn_sda_oe_n_o;
	logic        interrupt_out_n_o, interrupt_out_oe_n_o, lvds_clock_out_o, color_map_select_o;
	logic        low_freq_mode_o, repeater_mode_o, backward_compat_o, audio_port_b_select_o;
	logic        long_cable_mode_o, pclk_out_of_range_o;
	logic [3:0]  lvds_data_lanes_o;
	logic [2:0]  line_rate_mult_o;
	logic [27:0] panel_frame;
	int          cycles = 0, n_mismatch = 0, check_count = 0;
	wire logic   up_scl_i = (up_scl_oe_n_o | up_scl_o) & up_m_scl;
	wire logic   up_sda_i = (up_sda_oe_n_o | up_sda_o) & up_m_sda;
	wire logic   dn_scl_i = dn_scl_oe_n_o | dn_scl_o;
	wire logic   dn_sda_i = (dn_sda_oe_n_o | dn_sda_o) & dn_s_sda;
	wire logic   interrupt_in_n_i = int_drv;

	lpo_top dut_u (.*);
	lpo_panel_model panel_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .lanes_i(lvds_data_lanes_o),
		.clock_i(lvds_clock_out_o), .frame_o(panel_frame), .frame_stb_o(panel_stb));

	always #10 clk_i = ~clk_i;
	initial begin
		#11;
		forever #80 pixel_clk_i = pclk_run ? ~pixel_clk_i : 1'b0;
	end
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 4000) begin
			n_mismatch++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : report_and_stop

	task automatic chk(input string nm, input logic [27:0] exp, input logic [27:0] got);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : tick

	task automatic do_reset();
		rst_n_i = 1'b0;
		tick(5);
		rst_n_i = 1'b1;
		tick(8);
	endtask : do_reset

	function automatic logic [27:0] exp_frame(input logic [26:0] p, input logic m, input logic d);
		logic [5:0] r, g, b, lo;
		r = (m && !d) ? p[24:19] : p[26:21];
		g = (m && !d) ? p[16:11] : p[18:13];
		b = (m && !d) ? p[8:3] : p[10:5];
		lo = m ? {p[26:25], p[18:17], p[10:9]} : {p[20:19], p[12:11], p[4:3]};
		return {d ? 7'h00 : {lo, 1'b0}, p[0], p[1], p[2], b, g, r};
	endfunction : exp_frame

	task automatic run_cfg(input logic [1:0] k);
		logic [26:0] p [8];
		int n;
		color_map_reg_i = k[0];
		color_depth_18_i = k[1];
		pix_valid_i = 1'b1;
		for (int i = 0; i < 8; i++) begin
			p[i] = 27'(32'h05a3c6e1 ^ (i * 32'h01234567) ^ (k * 32'h00f0f0f1));
			pix_data_i = p[i];
			while (pix_ready_o !== 1'b1) tick(1);
			tick(1);
		end
		pix_data_i = 27'h7ffffff;
		tick(3);
		chk("ready when full", 28'h0, 28'(pix_ready_o));
		pix_valid_i = 1'b0;
		pclk_run = 1'b1;
		for (int i = 0; i < 9; i++) begin
			n = 0;
			do begin
				@(negedge clk_i);
				n++;
			end while (panel_stb !== 1'b1 && n < 40);
			chk("frame", (i < 8) ? exp_frame(p[i], k[0], k[1]) : 28'h0, panel_frame);
		end
		pclk_run = 1'b0;
		if (k == 2'h0) chk("range flag", 28'h1, 28'(pclk_out_of_range_o));
		tick(20);
	endtask : run_cfg

	initial begin
		logic [3:0] exp_m [9];
		exp_m = '{4'h0, 4'h2, 4'h8, 4'ha, 4'h1, 4'h3, 4'h9, 4'hb, 4'h4};
		do_reset();
		chk("ready", 28'h1, 28'(pix_ready_o));
		chk("low freq", 28'h0, 28'(low_freq_mode_o));
		for (int c = 0; c < 9; c++) begin
			mode_sel_code_i = 4'(c);
			do_reset();
			chk("mode", 28'(exp_m[c]), 28'({repeater_mode_o, backward_compat_o,
				audio_port_b_select_o, long_cable_mode_o}));
		end
		cfg_reg_en_i = 1'b1;
		repeat_reg_i = 1'b1;
		audio_port_b_reg_i = 1'b1;
		long_cable_reg_i = 1'b1;
		tick(4);
		chk("mode reg", 28'hb, 28'({repeater_mode_o, backward_compat_o,
			audio_port_b_select_o, long_cable_mode_o}));
		cfg_reg_en_i = 1'b0;
		mode_sel_code_i = 4'h0;
		do_reset();
		color_map_reg_en_i = 1'b1;
		for (int k = 0; k < 4; k++) run_cfg(2'(k));
		color_map_reg_en_i = 1'b0;
		color_map_strap_i = 1'b1;
		do_reset();
		chk("map strap", 28'h1, 28'(color_map_select_o));
		low_freq_strap_i = 1'b1;
		do_reset();
		chk("low freq", 28'h1, 28'(low_freq_mode_o));
		chk("mult", 28'h4, 28'(line_rate_mult_o));
		repeat_reg_i = 1'b0;
		audio_port_b_reg_i = 1'b0;
		long_cable_reg_i = 1'b0;
		backward_compat_reg_i = 1'b1;
		cfg_reg_en_i = 1'b1;
		tick(4);
		chk("mult compat", 28'h1, 28'(line_rate_mult_o));
		cfg_reg_en_i = 1'b0;
		backward_compat_reg_i = 1'b0;
		low_freq_strap_i = 1'b0;
		low_freq_reg_en_i = 1'b1;
		low_freq_reg_i = 1'b1;
		do_reset();
		chk("low freq reg", 28'h1, 28'(low_freq_mode_o));
		pclk_run = 1'b1;
		tick(40);
		chk("range flag", 28'h0, 28'(pclk_out_of_range_o));
		pclk_run = 1'b0;
		low_freq_reg_en_i = 1'b0;
		mode_sel_code_i = 4'h2;
		do_reset();
		up_m_scl = 1'b0;
		tick(12);
		chk("down clock pull", 28'h0, 28'(dn_scl_oe_n_o));
		up_m_scl = 1'b1;
		dn_s_sda = 1'b0;
		tick(12);
		chk("up data pull", 28'h0, 28'(up_sda_oe_n_o));
		dn_s_sda = 1'b1;
		alias_enable_i = 1'b1;
		alias_xor_i = 7'h40;
		tick(12);
		up_m_sda = 1'b0;
		tick(12);
		up_m_scl = 1'b0;
		tick(12);
		up_m_sda = 1'b1;
		tick(12);
		chk("alias data pull", 28'h0, 28'(dn_sda_oe_n_o));
		alias_enable_i = 1'b0;
		up_m_scl = 1'b1;
		int_drv = 1'b0;
		tick(12);
		chk("interrupt pull", 28'h0, 28'(interrupt_out_oe_n_o));
		cfg_reg_en_i = 1'b1;
		tick(4);
		chk("interrupt off", 28'h1, 28'(interrupt_out_oe_n_o));
		report_and_stop();
	end
endmodule : lpo_top_test

bind lpo_top lpo_top_sva chk_u (.*);
